// File: design/scra_regs.vh
// Purpose: constants of the serial register access block
// Assumes: included by bare name from the design files
// Notes: definitions only
//
// Behaviour
// RL1: sixteen-bit registers, one bit per falling edge
// RL2: words shift most significant bit first
// RL3: new value applied on following rising edge
// RL4: control word needs one write only
// RL5: host writes pointer, then data word
// RL6: read-out request applies control word at bit sixteen
// RL7: read-back on first output next read
// RL8: host waits forty cycles between accesses
// RL9: control word resets to zero
// RL10: fixed control word field layout
// RL11: differential mode uses upper select bit only
// RL12: pseudo-differential uses both select bits
// RL13: update scope limits applied control fields
// RL14: host never writes reserved scope code
// RL15: reference writes and read-back by pointer
// RL16: reference reset value, converter A lost
// RL17: channel tag precedes data unless disabled
// RL18: bits after sixteenth are ignored
`ifndef SCRA_REGS_VH
`define SCRA_REGS_VH

`define SCRA_WORD_W 16
`define SCRA_WORD_BITS 6'h10
`define SCRA_ACCESS_LEN 6'h28
`define SCRA_CNT_ZERO 6'h00
`define SCRA_CNT_ONE 6'h01
`define SCRA_TX_W 20
`define SCRA_TX_BITS 5'h14

// control word fields
`define SCRA_CHAN_HI 15
`define SCRA_CHAN_LO 14
`define SCRA_SCOPE_HI 13
`define SCRA_SCOPE_LO 12
`define SCRA_PWR_HI 11
`define SCRA_PWR_LO 10
`define SCRA_BUF_EN 9
`define SCRA_SPEC_RD 8
`define SCRA_FULL_CLK 7
`define SCRA_PSEUDO 6
`define SCRA_TAG_DIS 5
`define SCRA_PTR_HI 3
`define SCRA_PTR_LO 0

// update scope codes
`define SCRA_SCOPE_SEL0 2'h0
`define SCRA_SCOPE_ALL 2'h1
`define SCRA_SCOPE_TEST 2'h2
`define SCRA_SCOPE_SEL3 2'h3

// pointer codes (low three bits for reference writes)
`define SCRA_PTR_REFA_WR 3'h2
`define SCRA_PTR_REFB_WR 3'h5
`define SCRA_PTR_REFA_RD 4'h3
`define SCRA_PTR_REFB_RD 4'h6
`define SCRA_PTR_SEQ_WR 4'h4
`define SCRA_PTR_REFSEL_WR 4'h7
`define SCRA_PTR_SEQ_RD 4'h8
`define SCRA_PTR_REFSEL_RD 4'h9

// reference word fields
`define SCRA_REF_OFF 10
`define SCRA_REF_LVL_HI 9

// reset values
`define SCRA_CTRL_RST 16'h0000
`define SCRA_REF_RST 16'h07ff
`define SCRA_SEQ_RST 16'h0000
`define SCRA_REFSEL_RST 16'h0000

// write target codes
`define SCRA_TGT_NONE 3'h0
`define SCRA_TGT_REFA 3'h1
`define SCRA_TGT_REFB 3'h2
`define SCRA_TGT_SEQ 3'h3
`define SCRA_TGT_REFSEL 3'h4

`endif

// File: design/scra_shift.v
// Purpose: serial input deserialiser and access cycle counter
// Assumes: sampleEn marks a falling edge of the converter clock
// Notes: counts forty cycles per access
`timescale 1ns/1ps
`default_nettype none
`include "scra_regs.vh"
module scra_shift (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // serial side
  input wire sampleEn,
  input wire readStrobe,
  input wire serialBit,
  // word side
  output reg [`SCRA_WORD_W-1:0] word_reg,
  output reg wordDone_reg,
  output reg accessStart_reg,
  output wire accessBusy
);

reg [5:0] cnt_reg;

assign accessBusy = (cnt_reg != `SCRA_CNT_ZERO);

always @(posedge clock or negedge rst_n)
begin
  if (!rst_n)
  begin
    cnt_reg <= `SCRA_CNT_ZERO;
    word_reg <= `SCRA_CTRL_RST;
    wordDone_reg <= 1'b0;
    accessStart_reg <= 1'b0;
  end
  else
  begin
    wordDone_reg <= 1'b0;
    accessStart_reg <= 1'b0;
    if (sampleEn)
    begin
      if (cnt_reg == `SCRA_CNT_ZERO)
      begin
        if (readStrobe)
        begin
          cnt_reg <= `SCRA_CNT_ONE;
          accessStart_reg <= 1'b1;
          word_reg <= {word_reg[`SCRA_WORD_W-2:0], serialBit}; // RL2
        end
      end
      else
      begin
        if (cnt_reg < `SCRA_WORD_BITS)
        begin
          word_reg <= {word_reg[`SCRA_WORD_W-2:0], serialBit}; // RL1
          if (cnt_reg == `SCRA_WORD_BITS - `SCRA_CNT_ONE)
            wordDone_reg <= 1'b1;
        end
        // later bits fall through unsampled
        if (cnt_reg == `SCRA_ACCESS_LEN - `SCRA_CNT_ONE) // RL18
          cnt_reg <= `SCRA_CNT_ZERO;
        else
          cnt_reg <= cnt_reg + `SCRA_CNT_ONE;
      end
    end
  end
end

endmodule
`default_nettype wire

// File: design/scra_top.v
// Purpose: serial register bank of a dual sampling converter
// Assumes: converter clock and strobes are synchronous inputs, oversampled
// Notes: bits sampled on falling, applied and shifted on rising edges
`timescale 1ns/1ps
`default_nettype none
`include "scra_regs.vh"
module scra_top (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // converter serial link
  input wire convClock,
  input wire readStrobe,
  input wire serialInLine,
  input wire modeSelectLow,
  input wire bufferBusy,
  output reg firstSerialOut_reg,
  output reg firstOutEnable_n_reg,
  // register contents
  output reg [`SCRA_WORD_W-1:0] controlWord_reg,
  output reg [`SCRA_WORD_W-1:0] referenceLevelA_reg,
  output reg [`SCRA_WORD_W-1:0] referenceLevelB_reg,
  output reg [`SCRA_WORD_W-1:0] seqBufferSetup_reg,
  output reg [`SCRA_WORD_W-1:0] refSourceSelect_reg,
  // decoded state
  output reg [1:0] inputSelect_reg,
  output reg convALost_reg
);

reg clkPrev_reg;
reg applyPending_reg;
reg [2:0] target_reg;
reg readPending_reg;
reg readIsRef_reg;
reg [`SCRA_WORD_W-1:0] readWord_reg;
reg txArmed_reg;
reg [`SCRA_TX_W-1:0] tx_reg;
reg [4:0] txCnt_reg;
reg [`SCRA_WORD_W-1:0] ctrlNext;
wire fallEdge;
wire riseEdge;
wire [`SCRA_WORD_W-1:0] inWord;
wire wordDone;
wire accessStart;
wire [1:0] scope;
wire [3:0] ptr;

////////////////////////////////////////////////////////////////////////////////
// edge detect and control field taps
assign fallEdge = clkPrev_reg & ~convClock;
assign riseEdge = ~clkPrev_reg & convClock;
assign scope = inWord[`SCRA_SCOPE_HI:`SCRA_SCOPE_LO]; // RL10
assign ptr = inWord[`SCRA_PTR_HI:`SCRA_PTR_LO]; // RL10

////////////////////////////////////////////////////////////////////////////////
// deserialiser and access counter

scra_shift uShift (
  .clock(clock),
  .rst_n(rst_n),
  .sampleEn(fallEdge),
  .readStrobe(readStrobe),
  .serialBit(serialInLine),
  .word_reg(inWord),
  .wordDone_reg(wordDone),
  .accessStart_reg(accessStart),
  .accessBusy()
);

////////////////////////////////////////////////////////////////////////////////
// control word next value by update scope
always @*
begin
  ctrlNext = controlWord_reg;
  case (scope)
    `SCRA_SCOPE_ALL: ctrlNext = inWord; // RL13
    `SCRA_SCOPE_SEL0,
    `SCRA_SCOPE_SEL3:
    begin
      if (!modeSelectLow) // RL13
        ctrlNext[`SCRA_CHAN_HI:`SCRA_CHAN_LO] = inWord[`SCRA_CHAN_HI:`SCRA_CHAN_LO];
    end
    default: ctrlNext = controlWord_reg; // RL14
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// register update
always @(posedge clock or negedge rst_n)
begin
  if (!rst_n)
  begin
    clkPrev_reg <= 1'b1;
    applyPending_reg <= 1'b0;
    target_reg <= `SCRA_TGT_NONE;
    readPending_reg <= 1'b0;
    readIsRef_reg <= 1'b0;
    readWord_reg <= `SCRA_CTRL_RST;
    controlWord_reg <= `SCRA_CTRL_RST; // RL9
    referenceLevelA_reg <= `SCRA_REF_RST; // RL16
    referenceLevelB_reg <= `SCRA_REF_RST; // RL16
    seqBufferSetup_reg <= `SCRA_SEQ_RST;
    refSourceSelect_reg <= `SCRA_REFSEL_RST;
  end
  else
  begin
    clkPrev_reg <= convClock;
    if (wordDone)
      applyPending_reg <= 1'b1;
    if (txArmed_reg)
      readPending_reg <= 1'b0;
    if (applyPending_reg && riseEdge) // RL3
    begin
      applyPending_reg <= 1'b0;
      if (target_reg != `SCRA_TGT_NONE) // RL5
      begin
        target_reg <= `SCRA_TGT_NONE;
        case (target_reg)
          `SCRA_TGT_REFA: referenceLevelA_reg <= {5'h00, inWord[`SCRA_REF_OFF:0]}; // RL15
          `SCRA_TGT_REFB: referenceLevelB_reg <= {5'h00, inWord[`SCRA_REF_OFF:0]}; // RL15
          `SCRA_TGT_SEQ: seqBufferSetup_reg <= inWord;
          `SCRA_TGT_REFSEL: refSourceSelect_reg <= inWord;
          default: target_reg <= `SCRA_TGT_NONE;
        endcase
      end
      else
      begin
        controlWord_reg <= ctrlNext; // RL4
        if (scope == `SCRA_SCOPE_ALL) // RL6
        begin
          if (ptr[2:0] == `SCRA_PTR_REFA_WR)
            target_reg <= `SCRA_TGT_REFA;
          else if (ptr[2:0] == `SCRA_PTR_REFB_WR)
            target_reg <= `SCRA_TGT_REFB;
          else if (ptr == `SCRA_PTR_SEQ_WR)
            target_reg <= `SCRA_TGT_SEQ;
          else if (ptr == `SCRA_PTR_REFSEL_WR)
            target_reg <= `SCRA_TGT_REFSEL;
          readIsRef_reg <= (ptr == `SCRA_PTR_REFA_RD) || (ptr == `SCRA_PTR_REFB_RD);
          case (ptr)
            `SCRA_PTR_REFA_RD:
            begin
              readPending_reg <= 1'b1; // RL7
              readWord_reg <= referenceLevelA_reg;
            end
            `SCRA_PTR_REFB_RD:
            begin
              readPending_reg <= 1'b1;
              readWord_reg <= referenceLevelB_reg;
            end
            `SCRA_PTR_SEQ_RD:
            begin
              readPending_reg <= 1'b1;
              readWord_reg <= seqBufferSetup_reg;
            end
            `SCRA_PTR_REFSEL_RD:
            begin
              readPending_reg <= 1'b1;
              readWord_reg <= refSourceSelect_reg;
            end
            default: readWord_reg <= readWord_reg;
          endcase
        end
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// read-back on the first serial output
always @(posedge clock or negedge rst_n)
begin
  if (!rst_n)
  begin
    txArmed_reg <= 1'b0;
    tx_reg <= {`SCRA_TX_W{1'b0}};
    txCnt_reg <= 5'h00;
    firstSerialOut_reg <= 1'b0;
    firstOutEnable_n_reg <= 1'b1;
    convALost_reg <= 1'b0;
    inputSelect_reg <= 2'h0;
  end
  else
  begin
    if (controlWord_reg[`SCRA_PSEUDO]) // RL12
      inputSelect_reg <= controlWord_reg[`SCRA_CHAN_HI:`SCRA_CHAN_LO];
    else // RL11
      inputSelect_reg <= {1'b0, controlWord_reg[`SCRA_CHAN_HI]};
    if (accessStart && readPending_reg && !txArmed_reg)
    begin
      txArmed_reg <= 1'b1;
      convALost_reg <= readIsRef_reg; // RL16
      if (controlWord_reg[`SCRA_TAG_DIS]) // RL17
        tx_reg <= {readWord_reg, 4'h0};
      else // RL17
        tx_reg <= {inputSelect_reg, readWord_reg, 2'h0};
    end
    if (txArmed_reg && !bufferBusy && txCnt_reg == 5'h00) // RL7
    begin
      txArmed_reg <= 1'b0;
      txCnt_reg <= `SCRA_TX_BITS;
    end
    if (txCnt_reg != 5'h00 && riseEdge)
    begin
      firstSerialOut_reg <= tx_reg[`SCRA_TX_W-1]; // RL2
      firstOutEnable_n_reg <= 1'b0;
      tx_reg <= {tx_reg[`SCRA_TX_W-2:0], 1'b0};
      txCnt_reg <= txCnt_reg - 5'h01;
    end
    else if (txCnt_reg == 5'h00 && !txArmed_reg && riseEdge)
    begin
      firstSerialOut_reg <= 1'b0;
      firstOutEnable_n_reg <= 1'b1;
      convALost_reg <= 1'b0;
    end
  end
end

endmodule
`default_nettype wire

// File: test/scra_chk.sv
// Purpose: port assertions for the serial register block
// Assumes: bound to scra_top, one clock domain
// Notes: converter edges are seen one clock late
`timescale 1ns/1ps
`default_nettype none
module scra_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link
  input wire logic convClock,
  input wire logic bufferBusy,
  input wire logic firstSerialOut_reg,
  input wire logic firstOutEnable_n_reg,
  // registers
  input wire logic [15:0] controlWord_reg,
  input wire logic [15:0] referenceLevelA_reg,
  input wire logic [15:0] referenceLevelB_reg,
  input wire logic [15:0] seqBufferSetup_reg,
  input wire logic [15:0] refSourceSelect_reg,
  input wire logic [1:0] inputSelect_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // converter clock high for two samples
  sequence hiHeld;
    convClock && $past(convClock);
  endsequence
  sequence idleBusy;
    !$past(bufferBusy) && !$past(bufferBusy, 2);
  endsequence
  reset_vals_a: assert property ($rose(rst_n) |->
    {controlWord_reg, seqBufferSetup_reg, refSourceSelect_reg} == 48'h0
    && referenceLevelA_reg == 16'h07ff && referenceLevelB_reg == 16'h07ff)
    else $error("reset values wrong");
  ctrl_on_rise_a: assert property ($changed(controlWord_reg) |-> hiHeld)
    else $error("control word changed off rising edge");
  regs_on_rise_a: assert property ($changed({referenceLevelA_reg,
    referenceLevelB_reg, seqBufferSetup_reg, refSourceSelect_reg}) |-> hiHeld)
    else $error("register changed off rising edge");
  out_on_rise_a: assert property ($changed(firstSerialOut_reg) |-> hiHeld)
    else $error("serial out changed off rising edge");
  out_start_a: assert property ($fell(firstOutEnable_n_reg) |-> hiHeld ##0 idleBusy)
    else $error("read-back started badly");
  out_end_a: assert property ($rose(firstOutEnable_n_reg) |-> hiHeld)
    else $error("read-back ended off rising edge");
  input_dec_a: assert property (inputSelect_reg == ($past(controlWord_reg[6]) ?
    $past(controlWord_reg[15:14]) : {1'b0, $past(controlWord_reg[15])}))
    else $error("input select decode wrong");
  ref_upper_a: assert property ({referenceLevelA_reg[15:11],
    referenceLevelB_reg[15:11]} == 10'h000)
    else $error("reference upper bits set");
endmodule
bind scra_top scra_chk chk_u (.clock, .rst_n, .convClock, .bufferBusy,
  .firstSerialOut_reg, .firstOutEnable_n_reg, .controlWord_reg,
  .referenceLevelA_reg, .referenceLevelB_reg, .seqBufferSetup_reg,
  .refSourceSelect_reg, .inputSelect_reg);
`default_nettype wire

// File: test/scra_host.sv
// Purpose: host controller driving the serial link
// Assumes: tasks entered just after a rising system clock edge
// Notes: converter clock phase is four system clocks
`timescale 1ns/1ps
`default_nettype none
module scra_host (
  // clock
  input wire logic clock,
  // link out
  output logic convClock,
  output logic readStrobe,
  output logic serialInLine,
  // link in
  input wire logic firstSerialOut_reg,
  input wire logic firstOutEnable_n_reg,
  input wire logic convALost_reg
);
  initial
  begin
    convClock = 1'b1;
    readStrobe = 1'b0;
    serialInLine = 1'b0;
  end
  // one forty-cycle access, read-back bits collected
  task automatic access(input logic [15:0] w, output logic [19:0] rd,
    output logic lost);
    integer k;
    rd = 20'h0;
    lost = 1'b0;
    serialInLine = w[15];
    for (k = 0; k < 40; k = k + 1)
    begin
      readStrobe = (k == 0);
      convClock = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      readStrobe = 1'b0;
      convClock = 1'b1;
      serialInLine = (k < 15) ? w[14 - k] : ~serialInLine;
      repeat (4) @(posedge clock);
      #1;
      if (firstOutEnable_n_reg === 1'b0)
      begin
        rd = {rd[18:0], firstSerialOut_reg};
        lost = lost | convALost_reg;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: test/scra_top_test.sv
// Purpose: register bank test through the serial link
// Assumes: host model drives the converter link
// Notes: scope code 10 is never sent
`timescale 1ns/1ps
`default_nettype none
module scra_top_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic modeSelectLow = 1'b0;
  logic bufferBusy = 1'b0;
  wire convClock, readStrobe, serialInLine;
  logic firstSerialOut_reg, firstOutEnable_n_reg, convALost_reg;
  logic [15:0] controlWord_reg, referenceLevelA_reg, referenceLevelB_reg;
  logic [15:0] seqBufferSetup_reg, refSourceSelect_reg;
  logic [1:0] inputSelect_reg;
  logic [19:0] rd;
  logic [15:0] exp;
  logic lost;
  integer errCount = 0;
  integer checks = 0;
  integer cycles = 0;
  integer k;
  logic [15:0] wptr [4] = '{16'h1002, 16'h100d, 16'h1004, 16'h1007};
  logic [15:0] wdat [4] = '{16'hf955, 16'h0623, 16'h1234, 16'habcd};
  logic [15:0] rptr [4] = '{16'h1023, 16'h9046, 16'h1028, 16'hd009};
  logic [19:0] rexp [4] = '{20'h01550, 20'h8188c, 20'h12340, 20'h6af34};
  scra_top dut_u (.clock, .rst_n, .convClock, .readStrobe, .serialInLine,
    .modeSelectLow, .bufferBusy, .firstSerialOut_reg, .firstOutEnable_n_reg,
    .controlWord_reg, .referenceLevelA_reg, .referenceLevelB_reg,
    .seqBufferSetup_reg, .refSourceSelect_reg, .inputSelect_reg, .convALost_reg);
  scra_host host_u (.clock, .convClock, .readStrobe, .serialInLine,
    .firstSerialOut_reg, .firstOutEnable_n_reg, .convALost_reg);
  always #2 clock = ~clock;
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] want);
    checks = checks + 1;
    if (seen !== want)
    begin
      errCount = errCount + 1;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic finishTest;
    $display("checks %0d errors %0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 12000)
    begin
      errCount = errCount + 1;
      finishTest;
    end
  end
  initial
  begin
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check("ctrl", controlWord_reg, 16'h0000);
    check("refa", referenceLevelA_reg, 16'h07ff);
    host_u.access(16'h93f0, rd, lost);
    check("ctrl", controlWord_reg, 16'h93f0);
    exp = 16'h93f0;
    for (k = 0; k < 4; k = k + 1)
    begin
      modeSelectLow = k[1];
      host_u.access({k[0] ? 2'b11 : 2'b01, {2{k[0]}}, 12'hc00}, rd, lost);
      if (!k[1])
        exp[15:14] = k[0] ? 2'b11 : 2'b01;
      check("scope", controlWord_reg, exp);
    end
    modeSelectLow = 1'b0;
    check("insel", inputSelect_reg, 2'b11);
    host_u.access(16'h5000, rd, lost);
    check("insel", inputSelect_reg, 2'b00);
    for (k = 0; k < 4; k = k + 1)
    begin
      host_u.access(wptr[k], rd, lost);
      host_u.access(wdat[k], rd, lost);
      check("ctrl", controlWord_reg, wptr[k]);
    end
    check("refa", referenceLevelA_reg, 16'h0155);
    check("refb", referenceLevelB_reg, 16'h0623);
    check("seq", seqBufferSetup_reg, 16'h1234);
    check("refsel", refSourceSelect_reg, 16'habcd);
    for (k = 0; k < 4; k = k + 1)
    begin
      host_u.access(rptr[k], rd, lost);
      bufferBusy = (k == 2);
      fork
        host_u.access(rptr[k], rd, lost);
        if (k == 2)
        begin
          repeat (42) @(posedge clock);
          #1;
          check("busy", firstOutEnable_n_reg, 1'b1);
          bufferBusy = 1'b0;
        end
      join
      check("frame", rd, rexp[k]);
      check("lost", lost, k < 2);
    end
    finishTest;
  end
endmodule
`default_nettype wire
